// file: design/iepb_pkg.sv
package iepb_pkg;

    // ----------------------------------------
    // Register map and field layout
    // ----------------------------------------
    localparam logic [7:0] GATE_REG_ADDR = 8'hA8;
    localparam logic [7:0] LEVEL_UPPER_ADDR = 8'hB7;
    localparam logic [7:0] LEVEL_LOWER_ADDR = 8'hB8;
    localparam logic [7:0] STATUS_ADDR = 8'hB9;
    localparam logic [7:0] SERVICE_ADDR = 8'hBA;
    localparam int GLOBAL_GATE_POS = 7;
    localparam int UART_POS = 4;
    localparam int TIMER1_POS = 3;
    localparam int PIN1_POS = 2;
    localparam int TIMER0_POS = 1;
    localparam int PIN0_POS = 0;
    localparam int NUM_SRC = 5;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] SRC_FIELD_MASK = 8'h1F;
    localparam logic [7:0] GATE_FIELD_MASK = 8'h9F;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [1:0] iepb_level_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } iepb_bus_req_t;

    // Arbitration result toward the core
    typedef struct packed {
        logic valid;
        logic [2:0] src;
        iepb_level_t level;
    } iepb_grant_t;

    // Arbiter states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } iepb_state_t;

endpackage

// file: design/iepb_arbiter.sv
`timescale 1ns/100ps
`default_nettype none

// Combinational pick of the winning request: highest level, then poll order
module iepb_arbiter #(
    parameter int NSRC = 5
) (
    // Per-source inputs
    input wire logic [NSRC-1:0] req_ok,
    input wire logic [NSRC-1:0] lvl_hi,
    input wire logic [NSRC-1:0] lvl_lo,
    // Result
    output iepb_pkg::iepb_grant_t grant
);

    // ----------------------------------------
    // Search
    // ----------------------------------------
    // Scan from last poll position down so lower indices win ties
    always_comb begin
        grant = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            // [RULE_19] higher level first
            if (req_ok[i] && (!grant.valid || {lvl_hi[i], lvl_lo[i]} >= grant.level)) begin
                grant.valid = 1'b1;
                grant.src = 3'(i);
                // [RULE_17] level encoding
                grant.level = {lvl_hi[i], lvl_lo[i]};
            end
        end
    end

endmodule // iepb_arbiter

`default_nettype wire

// file: design/iepb_bank.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [RULE_01] Gate bit 7 low blocks every request
// [RULE_02] Gate high: each source uses own enable
// [RULE_03] Enable bit 4 gates serial port
// [RULE_04] Enable bit 3 gates timer 1
// [RULE_05] Enable bit 2 gates external pin 1
// [RULE_06] Enable bit 1 gates timer 0
// [RULE_07] Enable bit 0 gates external pin 0
// [RULE_08] Unused bits read any; never write ones
// [RULE_09] Enable register resets to zero, bit access
// [RULE_10] Serial level from bit 4 pair
// [RULE_11] Timer 1 level from bit 3 pair
// [RULE_12] Pin 1 level from bit 2 pair
// [RULE_13] Timer 0 level from bit 1 pair
// [RULE_14] Pin 0 level from bit 0 pair
// [RULE_15] Lower level register resets zero, bit access
// [RULE_16] Upper level register resets zero, byte only
// [RULE_17] Upper and lower bits encode levels 0-3
// [RULE_18] Preempt only by strictly higher level
// [RULE_19] Higher level first, ties by polling
// [RULE_20] Poll order pin0, t0, pin1, t1, uart
// [RULE_21] Writes act from next arbitration cycle
module iepb_bank #(
    parameter int NSRC = iepb_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    // Bit-addressed access: bit_wr writes bit_val into one bit of the enable or lower level register
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    output logic [7:0] rdata,
    // Sources, index order pin0, timer0, pin1, timer1, uart
    input wire logic [NSRC-1:0] src_req,
    // Core side
    input wire logic ack,
    input wire logic reti,
    output logic irq_valid,
    output logic [2:0] irq_src,
    output logic [1:0] irq_level
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] gate;                   // Enable register
        logic [7:0] upper;                  // Upper level register
        logic [7:0] lower;                  // Lower level register
        logic [3:0] active;                 // One bit per level in service
        logic [7:0] rdata;                  // Read data, one cycle late
        logic valid;                        // Request offered to core
        logic [2:0] src;                    // Offered source
        logic [1:0] level;                  // Offered level
        iepb_pkg::iepb_state_t st;          // Arbiter state
    } iepb_bank_state_t;

    iepb_bank_state_t s_q;  // Registered state
    iepb_bank_state_t s_d;  // Next state
    iepb_pkg::iepb_grant_t win;  // Arbitration winner
    logic [NSRC-1:0] req_ok;  // Enabled requests
    logic [NSRC-1:0] en_bits;  // Per-source enable
    logic [3:0] cur_lvl_mask;  // Levels that may preempt

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Highest active level as a mask of strictly-higher levels allowed
    function automatic logic [3:0] above_mask(input logic [3:0] act);
        logic [3:0] m;
        m = 4'hF;
        for (int l = 0; l < 4; l++) begin
            if (act[l]) begin
                m = 4'hF << (l + 1);
            end
        end
        return m;
    endfunction

    // Write one bit of a byte
    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                           input logic x);
        logic [7:0] r;
        r = v;
        r[b] = x;
        return r;
    endfunction

    // ----------------------------------------
    // Request gating
    // ----------------------------------------
    // [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07] per-source enables
    assign en_bits = s_q.gate[NSRC-1:0];

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_gate
            // [RULE_01] [RULE_02] global gate then own enable
            assign req_ok[g] = src_req[g] & en_bits[g] & s_q.gate[iepb_pkg::GLOBAL_GATE_POS];
        end
    endgenerate

    assign cur_lvl_mask = above_mask(s_q.active);

    // ----------------------------------------
    // Arbiter
    // ----------------------------------------
    // [RULE_10] [RULE_11] [RULE_12] [RULE_13] [RULE_14] bit pairs per source
    // [RULE_20] index order is poll order
    iepb_arbiter #(
        .NSRC(NSRC)
    ) u_arb (
        .req_ok(req_ok),
        .lvl_hi(s_q.upper[NSRC-1:0]),
        .lvl_lo(s_q.lower[NSRC-1:0]),
        .grant(win)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        // Register writes, whole byte
        if (wr) begin
            unique case (addr)
                // [RULE_09] gate register write
                iepb_pkg::GATE_REG_ADDR: begin
                    s_d.gate = wdata & iepb_pkg::GATE_FIELD_MASK;
                end
                iepb_pkg::LEVEL_UPPER_ADDR: begin
                    s_d.upper = wdata & iepb_pkg::SRC_FIELD_MASK;
                end
                iepb_pkg::LEVEL_LOWER_ADDR: begin
                    s_d.lower = wdata & iepb_pkg::SRC_FIELD_MASK;
                end
                default: begin
                end
            endcase
        end
        // Single-bit writes; the upper level register takes none
        if (bit_wr) begin
            unique case (addr)
                // [RULE_09] bit access on enable register
                iepb_pkg::GATE_REG_ADDR: begin
                    s_d.gate = set_bit(s_q.gate, bit_sel, bit_val) & iepb_pkg::GATE_FIELD_MASK;
                end
                // [RULE_15] bit access on lower register
                iepb_pkg::LEVEL_LOWER_ADDR: begin
                    s_d.lower = set_bit(s_q.lower, bit_sel, bit_val) & iepb_pkg::SRC_FIELD_MASK;
                end
                // [RULE_16] upper register ignores bit access
                default: begin
                end
            endcase
        end
        // Reads; unused bits return zero
        if (rd) begin
            unique case (addr)
                // [RULE_08] reserved bits read zero
                iepb_pkg::GATE_REG_ADDR: s_d.rdata = s_q.gate;
                iepb_pkg::LEVEL_UPPER_ADDR: s_d.rdata = s_q.upper;
                iepb_pkg::LEVEL_LOWER_ADDR: s_d.rdata = s_q.lower;
                iepb_pkg::STATUS_ADDR: s_d.rdata = {3'h0, req_ok};
                iepb_pkg::SERVICE_ADDR: s_d.rdata = {s_q.st == iepb_pkg::ST_BUSY, 3'h0,
                                                     s_q.active};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // [RULE_21] offer uses registered settings, new on next cycle
        s_d.valid = 1'b0;
        // [RULE_18] only strictly higher level may preempt
        if (win.valid && cur_lvl_mask[win.level] && !ack) begin
            s_d.valid = 1'b1;
            s_d.src = win.src;
            s_d.level = win.level;
        end
        // Level bookkeeping on accept and return
        if (reti) begin
            // Clear highest active level
            for (int l = 0; l < 4; l++) begin
                if (s_q.active[l] && (s_q.active >> (l + 1)) == 4'h0) begin
                    s_d.active[l] = 1'b0;
                end
            end
        end
        if (ack && s_q.valid) begin
            s_d.active[s_q.level] = 1'b1;
        end
        // State follows whether any routine runs
        unique case (s_q.st)
            iepb_pkg::ST_IDLE: begin
                if (ack && s_q.valid) begin
                    s_d.st = iepb_pkg::ST_BUSY;
                end
            end
            iepb_pkg::ST_BUSY: begin
                if (s_d.active == 4'h0) begin
                    s_d.st = iepb_pkg::ST_IDLE;
                end
            end
            default: s_d.st = iepb_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // [RULE_09] [RULE_15] [RULE_16] reset values
            s_q <= '{gate: iepb_pkg::GATE_RESET, upper: iepb_pkg::LEVEL_RESET,
                     lower: iepb_pkg::LEVEL_RESET, active: 4'h0, rdata: 8'h00,
                     valid: 1'b0, src: 3'h0, level: 2'h0, st: iepb_pkg::ST_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata = s_q.rdata;
    assign irq_valid = s_q.valid;
    assign irq_src = s_q.src;
    assign irq_level = s_q.level;

endmodule // iepb_bank

`default_nettype wire

// file: sim/iepb_props.sv
`timescale 1ns/100ps
`default_nettype none
module iepb_props #(
    parameter int NSRC = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic [7:0] rdata,
    // Requests and offer
    input wire logic [NSRC-1:0] src_req,
    input wire logic ack,
    input wire logic reti,
    input wire logic irq_valid,
    input wire logic [2:0] irq_src,
    input wire logic [1:0] irq_level
);
    logic [7:0] g_q, u_q, l_q;
    logic [NSRC-1:0] act;
    logic [3:0] svc_q;  // Shadow of the levels in service
    assign act = g_q[NSRC-1:0] & src_req;
    // Shadow copy of the three settings registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {g_q, u_q, l_q} <= 24'h000000;
        end else if (wr) begin
            if (addr == 8'hA8) g_q <= wdata & 8'h9F;
            if (addr == 8'hB7) u_q <= wdata & 8'h1F;
            if (addr == 8'hB8) l_q <= wdata & 8'h1F;
        end else if (bit_wr) begin
            if (addr == 8'hA8) begin
                g_q <= ((g_q & ~(8'h01 << bit_sel)) | (8'(bit_val) << bit_sel)) & 8'h9F;
            end
            if (addr == 8'hB8) begin
                l_q <= ((l_q & ~(8'h01 << bit_sel)) | (8'(bit_val) << bit_sel)) & 8'h1F;
            end
        end
    end
    // Levels in service: set on accept, highest cleared on return
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_q <= 4'h0;
        end else begin
            if (reti) begin
                for (int k = 0; k < 4; k++) begin
                    if (svc_q[k] && (svc_q >> (k + 1)) == 4'h0) begin
                        svc_q[k] <= 1'b0;
                    end
                end
            end
            if (ack && irq_valid) begin
                svc_q[irq_level] <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_rd_gate; $past(rd) && $past(addr) == 8'hA8 |-> rdata == $past(g_q); endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("enable readback");
    property p_rd_up; $past(rd) && $past(addr) == 8'hB7 |-> rdata == $past(u_q); endproperty
    a_rd_up: assert property (p_rd_up) else $error("upper readback");
    property p_rd_lo; $past(rd) && $past(addr) == 8'hB8 |-> rdata == $past(l_q); endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("lower readback");
    property p_gate; irq_valid |-> $past(g_q[7]); endproperty
    a_gate: assert property (p_gate) else $error("offer with gate off");
    property p_src_en; irq_valid |-> 1'($past(act) >> irq_src); endproperty
    a_src_en: assert property (p_src_en) else $error("offer of masked source");
    property p_level;
        irq_valid |-> irq_level == {1'($past(u_q) >> irq_src), 1'($past(l_q) >> irq_src)};
    endproperty
    a_level: assert property (p_level) else $error("wrong level");
    property p_ack_drop; ack |=> !irq_valid; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer stays after ack");
    property p_preempt; irq_valid |-> ($past(svc_q) >> irq_level) == 4'h0; endproperty
    a_preempt: assert property (p_preempt) else $error("offer not above service");
endmodule // iepb_props
bind iepb_bank iepb_props #(.NSRC(NSRC)) u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .bit_wr(bit_wr), .bit_sel(bit_sel),
    .bit_val(bit_val), .rdata(rdata), .src_req(src_req), .ack(ack), .reti(reti),
    .irq_valid(irq_valid), .irq_src(irq_src), .irq_level(irq_level));
`default_nettype wire

// file: sim/iepb_core.sv
`timescale 1ns/100ps
`default_nettype none
module iepb_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Offer and pacing
    input wire logic irq_valid,
    input wire logic [1:0] lag,
    input wire logic ret_now,
    output logic ack,
    output logic reti
);
    logic [1:0] cnt_q;
    logic [2:0] depth_q;
    // Accept only while offered, after lag waiting cycles
    assign ack = irq_valid && cnt_q == lag;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {cnt_q, depth_q, reti} <= 6'h00;
        end else begin
            cnt_q <= (irq_valid && !ack) ? cnt_q + 2'h1 : 2'h0;
            depth_q <= depth_q + 3'(ack) - 3'(reti);
            // Return only from a routine that was entered
            reti <= ret_now && depth_q != 3'h0;
        end
    end
endmodule // iepb_core
`default_nettype wire

// file: sim/iepb_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module iepb_bank_tb;
    logic clk, rst_n, wr, rd, bit_wr, bit_val, ack, reti, irq_valid, ret_now, rd_d;
    logic [7:0] addr, wdata, rdata, got, exp, v;
    logic [2:0] bit_sel, irq_src, s;
    logic [1:0] irq_level, lag;
    logic [4:0] src_req;
    logic [7:0] exp_q[$];
    int fails, total_checks, i, l, n;
    iepb_bank uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .rdata(rdata),
        .src_req(src_req), .ack(ack), .reti(reti), .irq_valid(irq_valid),
        .irq_src(irq_src), .irq_level(irq_level));
    iepb_core u_core (.clk(clk), .rst_n(rst_n), .irq_valid(irq_valid), .lag(lag),
        .ret_now(ret_now), .ack(ack), .reti(reti));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Oldest note against each read answer or accepted offer
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d || ack) begin
            got = rd_d ? rdata : {3'h0, irq_src, irq_level};
            exp = exp_q.size() > 0 ? exp_q.pop_front() : 8'hEE;
            total_checks++;
            if (got !== exp) begin
                fails++;
                $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
            end
        end
    end
    function automatic logic [7:0] ra(int k);
        return k == 0 ? 8'hA8 : 8'hB6 + 8'(k);
    endfunction
    task automatic test_done;
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, d, input logic w, r, b);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        bit_sel <= d[2:0];
        bit_val <= d[3];
        wr <= w;
        rd <= r;
        bit_wr <= b;
        @(posedge clk);
        {wr, rd, bit_wr} <= 3'h0;
    endtask
    task automatic rreg(input logic [7:0] a, e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0, 1'b1, 1'b0);
    endtask
    // Raise requests, wait boundedly for acceptance, then drop them
    task automatic grant(input logic [4:0] q, input logic [2:0] c, input logic [1:0] w,
        input logic hit);
        if (hit) exp_q.push_back({3'h0, c, w});
        @(posedge clk);
        src_req <= q;
        lag <= 2'($urandom % 3);
        for (n = 0; n < 30 && !(hit && ack === 1'b1); n++) @(posedge clk);
        src_req <= 5'h00;
        if (hit && n == 30) begin
            fails++;
            test_done();
        end
    endtask
    task automatic ret;
        @(posedge clk);
        ret_now <= 1'b1;
        @(posedge clk);
        ret_now <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        {addr, wdata, bit_sel, src_req, lag} = '0;
        {wr, rd, bit_wr, bit_val, ret_now, rd_d, rst_n} = '0;
        fails = 0;
        total_checks = 0;
        void'($urandom(32'hA975));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Two passes, each ended by a reset in mid-run
        for (l = 0; l < 2; l++) begin
            for (i = 0; i < 3; i++) rreg(ra(i), 8'h00);
            rreg(8'h10, 8'h00);
            for (i = 0; i < 3; i++) begin
                v = 8'($urandom) & (i == 0 ? 8'h9F : 8'h1F);
                bus(ra(i), v, 1'b1, 1'b0, 1'b0);
                rreg(ra(i), v);
            end
            @(posedge clk) rst_n <= 1'b0;
            @(posedge clk) rst_n <= 1'b1;
        end
        // Single-bit access per register
        bus(8'hB7, 8'h08, 1'b0, 1'b0, 1'b1);
        rreg(8'hB7, 8'h00);
        bus(8'hB8, 8'h0B, 1'b0, 1'b0, 1'b1);
        rreg(8'hB8, 8'h08);
        bus(8'hA8, 8'h0F, 1'b0, 1'b0, 1'b1);
        rreg(8'hA8, 8'h80);
        bus(8'hB8, 8'h00, 1'b1, 1'b0, 1'b0);
        bus(8'hA8, 8'h1F, 1'b1, 1'b0, 1'b0);
        grant(5'h1F, 3'h0, 2'h0, 1'b0);
        for (i = 0; i < 5; i++) begin
            bus(8'hA8, 8'h80 | (8'h01 << i), 1'b1, 1'b0, 1'b0);
            grant(5'h1F, 3'(i), 2'h0, 1'b1);
            ret();
        end
        // Each source at each level against the rest at level 0
        for (i = 0; i < 5; i++) begin
            for (l = 0; l < 4; l++) begin
                bus(8'hB7, 8'(l / 2) << i, 1'b1, 1'b0, 1'b0);
                bus(8'hB8, 8'(l % 2) << i, 1'b1, 1'b0, 1'b0);
                bus(8'hA8, 8'h9F, 1'b1, 1'b0, 1'b0);
                grant(5'h1F, 3'(l > 0 ? i : 0), 2'(l), 1'b1);
                ret();
            end
        end
        // Random tie sets at level 0: lowest index wins
        bus(8'hB7, 8'h00, 1'b1, 1'b0, 1'b0);
        bus(8'hB8, 8'h00, 1'b1, 1'b0, 1'b0);
        repeat (6) begin
            v = 8'($urandom % 31 + 1);
            for (i = 4; i >= 0; i--) if (v[i]) s = 3'(i);
            grant(v[4:0], s, 2'h0, 1'b1);
            ret();
        end
        // Nesting: only a strictly higher level pre-empts
        bus(8'hB7, 8'h10, 1'b1, 1'b0, 1'b0);
        bus(8'hB8, 8'h10, 1'b1, 1'b0, 1'b0);
        grant(5'h01, 3'h0, 2'h0, 1'b1);
        grant(5'h10, 3'h4, 2'h3, 1'b1);
        rreg(8'hBA, 8'h89);
        grant(5'h02, 3'h1, 2'h0, 1'b0);
        ret();
        grant(5'h02, 3'h1, 2'h0, 1'b0);
        ret();
        grant(5'h02, 3'h1, 2'h0, 1'b1);
        ret();
        test_done();
    end
endmodule // iepb_bank_tb
`default_nettype wire
